/* src/lie_regs.vh */
`ifndef LIE_REGS_VH
`define LIE_REGS_VH
`define LIE_AVL_AW 4
`define LIE_OFS_CTRL 4'h0
`define LIE_OFS_CFG 4'h1
`define LIE_OFS_STATUS 4'h2
`define LIE_OFS_RDATA 4'h3
`define LIE_OFS_CURSOR 4'h4
`define LIE_OFS_MEMADR 4'h5
`define LIE_OFS_MEMDAT 4'h6
`define LIE_CYC_CLEAR 8'hA5
`define LIE_CYC_NORMAL 8'h03
`define LIE_SPACE_CODE 8'h20
`define LIE_DRAM_LAST 7'h7F
`define LIE_GRAM_MASK 8'h1F
`define LIE_LINE_LEN_2 7'h28
`define LIE_LINE_LEN_4 7'h14
`define LIE_LINE_STEP_2 7'h40
`define LIE_LINE_STEP_4 7'h20
`define LIE_BLINK_HALF 17'h124F8
`define LIE_RST_SHIFT 7'h00
`endif

/* src/lie_ram.v */
`timescale 1ns/1ns
`include "lie_regs.vh"
// ****************************************************************
// Single-port memory with registered read data.
// ****************************************************************
module lie_ram (
  input wire i_clock,
  input wire i_we,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata
);
  reg [7:0] mem_q [0:255];

  always @(posedge i_clock) begin
    if (i_we) begin
      mem_q[i_addr] <= i_wdata;
    end
    o_rdata <= mem_q[i_addr];
  end
endmodule

/* src/lie_executor.v */
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "lie_regs.vh"
// Behaviour
// R1: Busy ignores all except busy read.
// R2: Host polls busy or waits maximum time.
// R3: Clear fills spaces, zeroes pointer, shift, increments.
// R4: Clear keeps busy 165 cycles.
// R5: Blind host waits 2 ms after clear.
// R6: Return home zeroes pointer and shift only.
// R7: Normal instructions take 3 cycles; NO_OPERATION zero.
// R8: Decode from highest set bit; zero NO_OPERATION.
// R9: Data access steps pointer per direction.
// R10: Auto-shift shifts display on display writes.
// R11: Display on flag shows or blanks display.
// R12: Cursor shown at pointer position when enabled.
// R13: Blink alternates with scaled period.
// R14: Cursor wraps to next line; lines shift together.
// R15: Display shift keeps pointer; cursor shift steps.
// R16: Bus width selects byte or nibble transfers.
// R17: Serial function set keeps bus width set.
// R18: Line count and mode select layout.
// R19: Glyph address set loads pointer bits 5..0.
// R20: Display address set loads full pointer.
// R21: Busy read returns busy and pointer.
// R22: Data write stores byte; glyph keeps five.
// R23: Data read gives holding, then steps, reloads.
// R24: Only address sets and reads reload holding.
// R25: Serial control byte carries continuation, select.
// R26: Busy appears on top data line.
module lie_executor (
  input wire i_clock,
  input wire i_rst_n,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  output wire o_busy_indicator,
  output wire [6:0] o_address_pointer,
  output wire o_display_on,
  output wire o_cursor_on,
  output wire o_blink_on,
  output wire o_blink_phase,
  output wire [6:0] o_display_shift,
  output wire [1:0] o_mux_layout
);
  // ****************************************************************
  // Architectural state
  // ****************************************************************
  reg busy_q;
  reg [7:0] busy_cnt_q;
  reg [6:0] ptr_q;
  reg sel_glyph_q;
  reg incr_q;
  reg auto_shift_q;
  reg disp_on_q;
  reg cur_on_q;
  reg blink_on_q;
  reg bus_width_q;
  reg line_cnt_q;
  reg line_mode_q;
  reg [6:0] shift_q;
  reg [7:0] hold_q;
  reg reload_q;
  reg reload2_q;
  reg clearing_q;
  reg [6:0] clr_adr_q;
  reg [16:0] blink_cnt_q;
  reg blink_ph_q;
  reg nib_phase_q;
  reg [3:0] nib_hi_q;
  reg rd_nib_q;
  reg cont_q;
  reg ack_q;
  reg [7:0] last_cmd_q;
  reg dropped_q;

  // Bus requests are answered one cycle after they arrive.
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
  wire take = (i_avs_read | i_avs_write) & ack_q;
  wire wr = take & i_avs_write;
  wire rd = take & i_avs_read;

  // Control register: [7:0] byte, [8] select, [9] read, [10] serial;
  // reads return the byte image of the data lines.
  wire ctl_wr = wr & (i_avs_address == `LIE_OFS_CTRL);
  wire ctl_rd = rd & (i_avs_address == `LIE_OFS_CTRL);
  wire c_rs = i_avs_writedata[8];
  wire c_serial = i_avs_writedata[10];

  // Nibble assembly in 4-bit parallel mode, high nibble first.
  wire nib_mode = ~bus_width_q & ~c_serial; // R16
  wire [7:0] in_byte = nib_mode ? {nib_hi_q, i_avs_writedata[7:4]}
                                : i_avs_writedata[7:0]; // R16
  wire byte_done = ctl_wr & (~nib_mode | nib_phase_q);

  // ****************************************************************
  // Decoding
  // ****************************************************************
  function [3:0] lie_decode;
    input [7:0] b;
    begin
      if (b[7]) lie_decode = 4'h9;
      else if (b[6]) lie_decode = 4'h8;
      else if (b[5]) lie_decode = 4'h7;
      else if (b[4]) lie_decode = 4'h6;
      else if (b[3]) lie_decode = 4'h5;
      else if (b[2]) lie_decode = 4'h4;
      else if (b[1]) lie_decode = 4'h3;
      else if (b[0]) lie_decode = 4'h2;
      else lie_decode = 4'h1;
    end
  endfunction

  localparam OP_NOP = 4'h1;
  localparam OP_CLR = 4'h2;
  localparam OP_HOME = 4'h3;
  localparam OP_ENTRY = 4'h4;
  localparam OP_DISP = 4'h5;
  localparam OP_SHIFT = 4'h6;
  localparam OP_FUNC = 4'h7;
  localparam OP_GADR = 4'h8;
  localparam OP_DADR = 4'h9;

  wire [3:0] op = lie_decode(in_byte); // R8
  // While busy, only the busy read is serviced; others are dropped.
  wire cmd_go = byte_done & ~c_rs & ~i_avs_writedata[9] & ~busy_q; // R1
  wire dat_go = byte_done & c_rs & ~i_avs_writedata[9] & ~busy_q; // R1
  // Data reads happen after the falling strobe, modelled by the read.
  wire rd_last = ctl_rd & (bus_width_q | rd_nib_q);
  wire drd_go = rd_last & last_cmd_q[0] & ~busy_q; // R23

  // Line length for cursor wrap in multi-line layouts.
  wire [6:0] line_len = line_mode_q ? `LIE_LINE_LEN_4 : `LIE_LINE_LEN_2;

  function [6:0] lie_step;
    input [6:0] a;
    input up;
    begin
      lie_step = up ? a + 7'h01 : a - 7'h01;
    end
  endfunction

  wire [6:0] ptr_step = lie_step(ptr_q, incr_q); // R9
  // Cursor shift right jumps to the next line after the last column when line_cnt_q is set and sel_glyph_q is clear.
  wire [6:0] line_base = line_mode_q ? {ptr_q[6:5], 5'h00}
                                     : {ptr_q[6], 6'h00};
  wire [6:0] line_next = line_mode_q ? line_base + `LIE_LINE_STEP_4
                                     : line_base + `LIE_LINE_STEP_2;
  wire [6:0] cur_right = (~sel_glyph_q & line_cnt_q &
                          (ptr_q - line_base == line_len - 7'h01)) ?
                         line_next : ptr_q + 7'h01; // R14
  wire [6:0] cur_left = ptr_q - 7'h01;

  // Memory port: shared for glyph (upper half) and display RAM.
  wire [7:0] ram_rdata;
  reg ram_we;
  reg [7:0] ram_addr;
  reg [7:0] ram_wdata;
  always @* begin
    ram_we = 1'b0;
    ram_addr = {sel_glyph_q, ptr_q};
    ram_wdata = in_byte;
    if (clearing_q) begin
      ram_we = 1'b1;
      ram_addr = {1'b0, clr_adr_q};
      ram_wdata = `LIE_SPACE_CODE; // R3
    end else if (dat_go) begin
      ram_we = 1'b1;
      ram_wdata = sel_glyph_q ? (in_byte & `LIE_GRAM_MASK) : in_byte; // R22
    end
  end

  lie_ram u_ram (
    .i_clock(i_clock),
    .i_we(ram_we),
    .i_addr(ram_addr),
    .i_wdata(ram_wdata),
    .o_rdata(ram_rdata)
  );

  // ****************************************************************
  // Execution
  // ****************************************************************
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      busy_q <= 1'b0;
      busy_cnt_q <= 8'h00;
      ptr_q <= 7'h00;
      sel_glyph_q <= 1'b0;
      incr_q <= 1'b1;
      auto_shift_q <= 1'b0;
      disp_on_q <= 1'b0;
      cur_on_q <= 1'b0;
      blink_on_q <= 1'b0;
      bus_width_q <= 1'b1;
      line_cnt_q <= 1'b0;
      line_mode_q <= 1'b0;
      shift_q <= `LIE_RST_SHIFT;
      hold_q <= 8'h00;
      reload_q <= 1'b0;
      reload2_q <= 1'b0;
      clearing_q <= 1'b0;
      clr_adr_q <= 7'h00;
      nib_phase_q <= 1'b0;
      nib_hi_q <= 4'h0;
      rd_nib_q <= 1'b0;
      cont_q <= 1'b0;
      ack_q <= 1'b0;
      last_cmd_q <= 8'h00;
      dropped_q <= 1'b0;
    end else begin
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
      reload2_q <= reload_q;
      reload_q <= 1'b0;
      if (reload2_q) begin
        hold_q <= ram_rdata; // R24
      end
      if (ctl_wr) begin
        last_cmd_q <= {7'h00, c_rs & i_avs_writedata[9]};
        if (nib_mode) begin
          nib_phase_q <= ~nib_phase_q; // R16
          nib_hi_q <= i_avs_writedata[7:4];
        end
      end
      if (ctl_rd & ~bus_width_q) begin
        rd_nib_q <= ~rd_nib_q; // R16
      end
      // Serial control byte: continuation then select and direction.
      if (wr & (i_avs_address == `LIE_OFS_CFG)) begin
        cont_q <= i_avs_writedata[7]; // R25
        dropped_q <= 1'b0;
      end
      if (byte_done & busy_q) begin
        dropped_q <= 1'b1; // R1
      end
      if (busy_q) begin
        if (busy_cnt_q == 8'h01) begin
          busy_q <= 1'b0;
        end
        busy_cnt_q <= busy_cnt_q - 8'h01;
      end
      if (clearing_q) begin
        clr_adr_q <= clr_adr_q + 7'h01;
        if (clr_adr_q == `LIE_DRAM_LAST) begin
          clearing_q <= 1'b0;
        end
      end
      if (cmd_go & op != OP_NOP) begin
        busy_q <= 1'b1;
        busy_cnt_q <= (op == OP_CLR) ? `LIE_CYC_CLEAR : `LIE_CYC_NORMAL; // R4 R7
      end
      if (dat_go | drd_go) begin
        busy_q <= 1'b1;
        busy_cnt_q <= `LIE_CYC_NORMAL; // R7
        ptr_q <= ptr_step; // R9
        if (drd_go) begin
          reload_q <= 1'b1; // R23
        end
        if (dat_go & auto_shift_q & ~sel_glyph_q) begin
          shift_q <= incr_q ? shift_q - 7'h01 : shift_q + 7'h01; // R10
        end
      end
      if (cmd_go) begin
        case (op)
          OP_CLR: begin
            clearing_q <= 1'b1; // R3
            clr_adr_q <= 7'h00;
            ptr_q <= 7'h00;
            sel_glyph_q <= 1'b0;
            shift_q <= `LIE_RST_SHIFT;
            incr_q <= 1'b1;
          end
          OP_HOME: begin
            ptr_q <= 7'h00; // R6
            sel_glyph_q <= 1'b0;
            shift_q <= `LIE_RST_SHIFT;
          end
          OP_ENTRY: begin
            incr_q <= in_byte[1];
            auto_shift_q <= in_byte[0];
          end
          OP_DISP: begin
            disp_on_q <= in_byte[2]; // R11
            cur_on_q <= in_byte[1];
            blink_on_q <= in_byte[0];
          end
          OP_SHIFT: begin
            if (in_byte[3]) begin
              shift_q <= in_byte[2] ? shift_q + 7'h01
                                    : shift_q - 7'h01; // R14 R15
            end else begin
              ptr_q <= in_byte[2] ? cur_right : cur_left; // R15
            end
          end
          OP_FUNC: begin
            bus_width_q <= in_byte[4] | c_serial; // R17
            line_cnt_q <= in_byte[3]; // R18
            line_mode_q <= in_byte[2];
            nib_phase_q <= 1'b0;
          end
          OP_GADR: begin
            ptr_q <= {ptr_q[6], in_byte[5:0]}; // R19
            sel_glyph_q <= 1'b1;
            reload_q <= 1'b1; // R24
          end
          OP_DADR: begin
            ptr_q <= in_byte[6:0]; // R20
            sel_glyph_q <= 1'b0;
            reload_q <= 1'b1; // R24
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Blink timing: half period of 0.5 s at 150 kHz oscillator.
  // ****************************************************************
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      blink_cnt_q <= 17'h00000;
      blink_ph_q <= 1'b0;
    end else if (blink_cnt_q == `LIE_BLINK_HALF - 17'h00001) begin
      blink_cnt_q <= 17'h00000;
      blink_ph_q <= ~blink_ph_q; // R13
    end else begin
      blink_cnt_q <= blink_cnt_q + 17'h00001;
    end
  end

  // ****************************************************************
  // Register read side
  // ****************************************************************
  wire [7:0] status_byte = {busy_q, ptr_q}; // R21 R26
  wire c_rs_rd = i_avs_writedata[8] | last_cmd_q[0];
  wire [7:0] lane_byte = c_rs_rd ? hold_q : status_byte;
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_avs_read & ~ack_q) begin
      case (i_avs_address)
        `LIE_OFS_CTRL: o_avs_readdata <= {24'h000000,
          (~bus_width_q & rd_nib_q) ? {lane_byte[3:0], 4'h0}
                                    : lane_byte}; // R16 R26
        `LIE_OFS_CFG: o_avs_readdata <= {22'h000000, dropped_q, cont_q,
          line_mode_q, line_cnt_q, bus_width_q, auto_shift_q, incr_q,
          blink_on_q, cur_on_q, disp_on_q};
        `LIE_OFS_STATUS: o_avs_readdata <= {23'h000000, sel_glyph_q,
          status_byte};
        `LIE_OFS_RDATA: o_avs_readdata <= {24'h000000, hold_q};
        `LIE_OFS_CURSOR: o_avs_readdata <= {25'h0000000, shift_q};
        default: o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // Cursor and blink are suppressed while the glyph RAM is the target.
  assign o_busy_indicator = busy_q;
  assign o_address_pointer = ptr_q;
  assign o_display_on = disp_on_q; // R11
  assign o_cursor_on = cur_on_q & ~sel_glyph_q; // R12 R9
  assign o_blink_on = blink_on_q & ~sel_glyph_q; // R13
  assign o_blink_phase = blink_ph_q;
  assign o_display_shift = shift_q;
  assign o_mux_layout = {line_mode_q, line_cnt_q}; // R18
endmodule

/* verif/lie_executor_assertions.sv */
`timescale 1ns/1ns
// ****************************************************************
// Port checks for the instruction executor.
// ****************************************************************
module lie_chk (
  input wire i_clock,
  input wire i_rst_n,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  input wire o_busy_indicator,
  input wire [6:0] o_address_pointer,
  input wire o_display_on,
  input wire o_cursor_on,
  input wire o_blink_on,
  input wire o_blink_phase,
  input wire [6:0] o_display_shift,
  input wire [1:0] o_mux_layout
);
  reg [7:0] busy_q;
  wire ctl_w = i_avs_write && i_avs_address == 4'h0 && !o_avs_waitrequest;
  wire acc = ctl_w && !o_busy_indicator && !i_avs_writedata[8];
  wire [7:0] b = i_avs_writedata[7:0];
  // Length of the current busy run, read when busy falls.
  always @(posedge i_clock) begin
    if (!i_rst_n || !o_busy_indicator) begin
      busy_q <= 8'h00;
    end else begin
      busy_q <= busy_q + 8'h01;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_read_answer:
    assert property ($rose(i_avs_read) |-> o_avs_waitrequest
      ##1 !o_avs_waitrequest) else $error("Read not answered.");
  a_busy_span:
    assert property ($fell(o_busy_indicator) |->
      busy_q == 8'hA5 || busy_q == 8'h03) else $error("Busy span.");
  a_nop_idle:
    assert property (acc && b == 8'h00 |=> !o_busy_indicator [*3])
      else $error("No-op went busy.");
  a_drop_busy:
    assert property (ctl_w && o_busy_indicator |=>
      $stable(o_address_pointer) [*3]) else $error("Busy not dropped.");
  a_clear_busy:
    assert property (acc && b == 8'h01 |-> ##[1:5] o_busy_indicator)
      else $error("Clear not busy.");
  a_addr_load:
    assert property (acc && b[7] |-> ##[1:5]
      o_address_pointer == i_avs_writedata[6:0]) else $error("Addr.");
  a_disp_ctl:
    assert property (acc && b[7:3] == 5'h01 |-> ##[1:5]
      o_display_on == i_avs_writedata[2]) else $error("Display.");
  a_func_set:
    assert property (acc && b[7:5] == 3'h1 |-> ##[1:5]
      o_mux_layout == {i_avs_writedata[2], i_avs_writedata[3]})
      else $error("Layout.");
  c_clear: cover property (acc && b == 8'h01);
  c_busy_read: cover property (o_busy_indicator && i_avs_read);
  c_glyph: cover property (acc && b[7:6] == 2'b01);
endmodule

/* verif/lie_host.sv */
`timescale 1ns/1ns
// ****************************************************************
// Host microcontroller on the register bus.
// ****************************************************************
module lie_host (
  input wire i_clock,
  input wire [31:0] i_avs_readdata,
  input wire i_avs_waitrequest,
  output reg [3:0] o_avs_address = 4'h0,
  output reg o_avs_read = 1'b0,
  output reg o_avs_write = 1'b0,
  output reg [31:0] o_avs_writedata = 32'h0
);
  // Waitrequest and read data are taken at the edge that ends the wait.
  // The idle edge after release keeps two requests from touching.
  task bus(input bit we, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
    begin
      o_avs_address <= a;
      o_avs_write <= we;
      o_avs_read <= !we;
      if (we) o_avs_writedata <= d;
      do begin
        @(posedge i_clock);
      end while (i_avs_waitrequest !== 1'b0);
      q = i_avs_readdata;
      o_avs_write <= 1'b0;
      o_avs_read <= 1'b0;
      @(posedge i_clock);
    end
  endtask
  // Write data is left alone while polling, so it still names the command.
  task idle();
    logic [31:0] q;
    begin
      do begin
        bus(1'b0, 4'h2, 32'h0, q);
      end while (q[7] !== 1'b0);
    end
  endtask
  task cmd(input logic [9:0] w);
    logic [31:0] q;
    begin
      bus(1'b1, 4'h0, {22'h0, w}, q);
      idle();
    end
  endtask
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ns
// ****************************************************************
// Instruction executor bench.
// ****************************************************************
module tb_top;
  reg i_clock = 1'b0;
  reg i_rst_n = 1'b0;
  wire [3:0] adr;
  wire rd;
  wire wr;
  wire [31:0] wd;
  wire [31:0] q;
  wire wt;
  wire bsy;
  wire [6:0] ptr;
  wire [6:0] shf;
  wire [1:0] lay;
  wire d_on;
  wire c_on;
  wire b_on;
  int error_cnt = 0;
  int tests_run = 0;
  logic [31:0] r;
  logic [7:0] dc [3] = '{8'h0F, 8'h08, 8'h0D};
  logic [7:0] fs [3] = '{8'h38, 8'h3C, 8'h30};
  always #5 i_clock = ~i_clock;
  lie_host h (.i_clock(i_clock), .i_avs_readdata(q),
    .i_avs_waitrequest(wt), .o_avs_address(adr), .o_avs_read(rd),
    .o_avs_write(wr), .o_avs_writedata(wd));
  lie_executor i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .o_avs_readdata(q), .o_avs_waitrequest(wt),
    .o_busy_indicator(bsy), .o_address_pointer(ptr),
    .o_display_on(d_on), .o_cursor_on(c_on), .o_blink_on(b_on),
    .o_blink_phase(), .o_display_shift(shf), .o_mux_layout(lay));
  task chk(input logic [31:0] s, input logic [31:0] e);
    begin
      tests_run++;
      if (s !== e) begin
        error_cnt++;
        $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  // Port values are taken mid-cycle, clear of the edge that updates them.
  task pk(input int f, input logic [6:0] e);
    logic [6:0] s;
    begin
      @(negedge i_clock);
      case (f)
        0: s = ptr;
        1: s = shf;
        2: s = {5'h0, lay};
        3: s = {4'h0, d_on, c_on, b_on};
        default: s = {6'h0, |shf};
      endcase
      chk(s, e);
      @(posedge i_clock);
    end
  endtask
  task report_and_stop();
    begin
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    h.bus(1'b0, 4'h2, 32'h0, r);
    chk(r[8:0], 9'h000);
    h.cmd(10'h000);
    pk(0, 7'h00);
    h.cmd(10'h085);
    h.cmd(10'h141);
    pk(0, 7'h06);
    h.cmd(10'h004);
    h.cmd(10'h142);
    pk(0, 7'h05);
    h.bus(1'b1, 4'h0, 32'h001, r);
    h.bus(1'b1, 4'h0, 32'h085, r);
    h.bus(1'b0, 4'h2, 32'h0, r);
    chk(r[7], 1'b1);
    h.idle();
    pk(0, 7'h00);
    pk(1, 7'h00);
    h.cmd(10'h155);
    pk(0, 7'h01);
    h.cmd(10'h081);
    h.cmd(10'h166);
    h.bus(1'b0, 4'h3, 32'h0, r);
    chk(r[7:0], 8'h20);
    h.cmd(10'h081);
    h.cmd(10'h300);
    h.bus(1'b0, 4'h0, 32'h0, r);
    chk(r[7:0], 8'h66);
    h.idle();
    pk(0, 7'h02);
    h.bus(1'b0, 4'h3, 32'h0, r);
    chk(r[7:0], 8'h20);
    for (int i = 0; i < 3; i++) begin
      h.cmd({2'b00, dc[i]});
      pk(3, dc[i][2:0]);
      h.cmd({2'b00, fs[i]});
      pk(2, {fs[i][2], fs[i][3]});
    end
    h.cmd(10'h018);
    pk(0, 7'h02);
    pk(4, 7'h01);
    pk(1, 7'h7F);
    h.cmd(10'h014);
    pk(0, 7'h03);
    h.cmd(10'h038);
    h.cmd(10'h0A7);
    h.cmd(10'h014);
    pk(0, 7'h40);
    h.cmd(10'h03C);
    h.cmd(10'h093);
    h.cmd(10'h014);
    pk(0, 7'h20);
    h.cmd(10'h002);
    pk(0, 7'h00);
    pk(1, 7'h00);
    h.cmd(10'h007);
    h.cmd(10'h131);
    pk(4, 7'h01);
    pk(1, 7'h7F);
    pk(0, 7'h01);
    h.cmd(10'h00E);
    h.cmd(10'h0C0);
    h.cmd(10'h043);
    pk(0, 7'h43);
    pk(3, 7'h04);
    h.cmd(10'h1FF);
    pk(0, 7'h44);
    h.cmd(10'h043);
    h.bus(1'b0, 4'h3, 32'h0, r);
    chk(r[7:0], 8'h1F);
    h.cmd(10'h002);
    h.bus(1'b0, 4'h1, 32'h0, r);
    chk(r[9], 1'b1);
    h.bus(1'b1, 4'h1, 32'h080, r);
    h.bus(1'b1, 4'h0, 32'h420, r);
    h.idle();
    h.bus(1'b0, 4'h1, 32'h0, r);
    chk(r[9:5], 5'h09);
    h.cmd(10'h020);
    h.bus(1'b0, 4'h1, 32'h0, r);
    chk(r[5], 1'b0);
    h.cmd(10'h080);
    h.cmd(10'h050);
    pk(0, 7'h05);
    report_and_stop();
  end
endmodule
bind lie_executor lie_chk i_chk (
  .i_clock(i_clock),
  .i_rst_n(i_rst_n),
  .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest),
  .o_busy_indicator(o_busy_indicator),
  .o_address_pointer(o_address_pointer),
  .o_display_on(o_display_on),
  .o_cursor_on(o_cursor_on),
  .o_blink_on(o_blink_on),
  .o_blink_phase(o_blink_phase),
  .o_display_shift(o_display_shift),
  .o_mux_layout(o_mux_layout)
);
